// ==== rtl/nand_host_ctrl.sv ====
// host controller driving a nand flash over its strobe pins and 8-bit port
// assumes busy_flag_n is pulled up outside; port wire resolved outside from port_oe
`timescale 1ns/1ps
`default_nettype none

module nand_host_ctrl
  import nand_host_pkg::*;
#(
  parameter int PHASE_CYC = `PHASE_CYC,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic op_done,
  output logic op_refused,
  input wire logic write_allow,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] status_byte,
  output logic status_fail,
  output logic cmd_latch_en,
  output logic addr_latch_en,
  output logic chip_select_n,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic wr_protect_n,
  output logic [7:0] port_out,
  output logic port_oe,
  input wire logic [7:0] port_in,
  input wire logic busy_flag_n
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  ctl_t r, n;
  logic tick;
  logic [7:0] fifo_data;
  logic fifo_valid, fifo_ready;

  function automatic logic [7:0] addr_byte(input req_t q, input logic [2:0] idx);
    logic [7:0] b;
    b = `ID_ADDR_BYTE;
    unique case (idx)
      3'd0: b = q.col[7:0];
      3'd1: b = {3'h0, q.col[`COL_W-1:8]};
      3'd2: b = q.row[7:0];
      3'd3: b = q.row[15:8];
      3'd4: b = {6'h00, q.row[`ROW_W-1:16]};
      default: b = `ID_ADDR_BYTE;
    endcase
    return b;
  endfunction

  function automatic logic pair_ok(input logic [`ROW_W-1:0] a, input logic [`ROW_W-1:0] b);
    return (a[`DIST_BIT] != b[`DIST_BIT]) && (a[`HALF_BIT] == b[`HALF_BIT])
      && (a[`PAGE_W-1:0] == b[`PAGE_W-1:0]);
  endfunction

  // request to cycle descriptor
  function automatic desc_t desc_of(input req_t q);
    desc_t d;
    d = '0;
    d.has_cmd1 = 1'b1;
    unique case (q.op)
      OP_READ: begin
        d.cmd1 = `CMD_READ1; d.has_addr = 1'b1; d.a_first = `AB_COL0; d.a_last = `AB_ROW2;
        d.has_cmd2 = 1'b1; d.cmd2 = `CMD_READ2; d.wait_rdy = 1'b1;
      end
      OP_READ_COL: begin
        d.cmd1 = `CMD_COLR1; d.has_addr = 1'b1; d.a_first = `AB_COL0; d.a_last = `AB_COL1;
        d.has_cmd2 = 1'b1; d.cmd2 = `CMD_COLR2; d.dir = DIR_OUT;
      end
      OP_CACHE_NEXT: begin
        d.cmd1 = `CMD_CACHE_NEXT; d.wait_rdy = 1'b1;
      end
      OP_CACHE_LAST: begin
        d.cmd1 = `CMD_CACHE_LAST; d.wait_rdy = 1'b1;
      end
      OP_MREAD_FIRST: begin
        d.cmd1 = `CMD_MULTI_RD1; d.has_addr = 1'b1; d.a_first = `AB_ROW0; d.a_last = `AB_ROW2;
      end
      OP_MREAD_SECOND: begin
        d.cmd1 = `CMD_MULTI_RD1; d.has_addr = 1'b1; d.a_first = `AB_ROW0; d.a_last = `AB_ROW2;
        d.has_cmd2 = 1'b1; d.cmd2 = `CMD_READ2; d.wait_rdy = 1'b1;
      end
      OP_PROG, OP_PROG_SECOND, OP_COPY_PROG: begin
        d.cmd1 = (q.op == OP_PROG) ? `CMD_PROG1 :
          (q.op == OP_PROG_SECOND) ? `CMD_PROG_2ND : `CMD_COPY_PROG;
        d.has_addr = 1'b1; d.a_first = `AB_COL0; d.a_last = `AB_ROW2; d.dir = DIR_IN;
      end
      OP_PROG_COL: begin
        d.cmd1 = `CMD_PROG_COL; d.has_addr = 1'b1; d.a_first = `AB_COL0; d.a_last = `AB_COL1;
        d.dir = DIR_IN;
      end
      OP_COPY_READ: begin
        d.cmd1 = `CMD_READ1; d.has_addr = 1'b1; d.a_first = `AB_COL0; d.a_last = `AB_ROW2;
        d.has_cmd2 = 1'b1; d.cmd2 = `CMD_COPY_RD2; d.wait_rdy = 1'b1;
      end
      OP_ERASE: begin
        d.cmd1 = `CMD_ERASE1; d.has_addr = 1'b1; d.a_first = `AB_ROW0; d.a_last = `AB_ROW2;
        d.has_cmd2 = 1'b1; d.cmd2 = `CMD_ERASE2; d.wait_rdy = 1'b1;
      end
      OP_ID: begin
        d.cmd1 = `CMD_ID; d.has_addr = 1'b1; d.a_first = `AB_ID; d.a_last = `AB_ID;
        d.dir = DIR_OUT;
      end
      OP_STATUS: begin
        d.cmd1 = `CMD_STATUS; d.dir = DIR_OUT;
      end
      OP_STATUS_MULTI: begin
        d.cmd1 = `CMD_STATUS_MULTI; d.dir = DIR_OUT;
      end
      OP_RESET: begin
        d.cmd1 = `CMD_RESET; d.wait_rdy = 1'b1;
      end
      OP_DATA_OUT: begin
        d.has_cmd1 = 1'b0; d.dir = DIR_OUT;
      end
      default: d.has_cmd1 = 1'b0;
    endcase
    // confirm picked by request on program kinds
    if (d.dir == DIR_IN && q.conf != CONF_NONE) begin
      d.has_cmd2 = 1'b1;
      d.wait_rdy = 1'b1;
      d.cmd2 = (q.conf == CONF_10) ? `CMD_CONF_PROG :
        (q.conf == CONF_15) ? `CMD_CONF_CACHE : `CMD_CONF_MULTI;
    end
    return d;
  endfunction

  // next stage: 0 cmd1, 1 addr, 2 data in, 3 cmd2, 4 data out, 5 wait
  function automatic state_t after(input desc_t d, input logic [2:0] from);
    state_t s;
    s = S_IDLE;
    if (from < 3'd1 && d.has_addr) s = S_ADDR;
    else if (from < 3'd2 && d.dir == DIR_IN) s = S_DATA;
    else if (from < 3'd3 && d.has_cmd2) s = S_CMD2;
    else if (from < 3'd4 && d.dir == DIR_OUT) s = S_DATA;
    else if (from < 3'd5 && d.wait_rdy) s = S_WAITB;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sub modules

  phase_tick #(.DIV(PHASE_CYC)) u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .tick(tick)
  );

  byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  logic writes, bad;
  desc_t dq;
  assign dq = desc_of(req);
  assign writes = (req.op inside {OP_PROG, OP_PROG_SECOND, OP_PROG_COL, OP_COPY_PROG, OP_ERASE});
  assign req_ready = (r.state == S_IDLE);
  // pop a program byte at the falling write phase
  assign fifo_ready = (r.state == S_DATA) && (r.d.dir == DIR_IN) && !r.ph && tick;

  // request legality
  always_comb begin
    bad = 1'b0;
    // busy accepts only status and reset
    if (!r.busy_s2 && !(req.op inside {OP_STATUS, OP_STATUS_MULTI, OP_RESET})) bad = 1'b1;
    // no program or erase under protect
    if (writes && !write_allow) bad = 1'b1;
    // cached read must be closed first
    if (r.cache_act && (writes || req.op inside {OP_COPY_READ, OP_MREAD_FIRST})) bad = 1'b1;
    if (req.op inside {OP_CACHE_NEXT, OP_CACHE_LAST} && !r.rd_ctx) bad = 1'b1;
    if (req.op == OP_PROG_COL && !r.prog_open) bad = 1'b1;
    if (req.op == OP_PROG_SECOND && !(r.mp_prog && pair_ok(r.mp_row, req.row))) bad = 1'b1;
    if (req.op == OP_MREAD_SECOND && !(r.mp_open && pair_ok(r.mp_row, req.row))) bad = 1'b1;
    if (!dq.has_cmd1 && dq.dir == DIR_NONE) bad = 1'b1;
  end

  // next state of all controller state
  always_comb begin
    n = r;
    n.err = 1'b0;
    n.done = 1'b0;
    n.rd_valid = 1'b0;
    n.busy_s1 = busy_flag_n;
    n.busy_s2 = r.busy_s1;
    n.din_s1 = port_in;
    n.din_s2 = r.din_s1;
    unique case (r.state)
      S_IDLE: begin
        if (req_valid && bad) begin
          n.err = 1'b1;
        end else if (req_valid) begin
          n.rq = req;
          n.d = dq;
          n.ph = 1'b0;
          n.ab = dq.a_first;
          n.cnt = (req.op inside {OP_STATUS, OP_STATUS_MULTI}) ? `LEN_W'(1) : req.len;
          n.state = dq.has_cmd1 ? S_CMD1 : after(dq, 3'd3);
          if (req.op inside {OP_READ, OP_CACHE_NEXT}) n.rd_ctx = 1'b1;
          if (req.op == OP_CACHE_NEXT) n.cache_act = 1'b1;
          if (req.op inside {OP_READ, OP_CACHE_LAST, OP_RESET}) n.cache_act = 1'b0;
          if (req.op inside {OP_CACHE_LAST, OP_RESET, OP_COPY_READ, OP_MREAD_FIRST} || writes) begin
            n.rd_ctx = 1'b0;
          end
          if (!(req.op inside {OP_STATUS, OP_STATUS_MULTI, OP_DATA_OUT, OP_READ_COL})) begin
            n.mp_open = (req.op == OP_MREAD_FIRST);
            n.mp_prog = (req.op == OP_PROG) && (req.conf == CONF_11);
            n.prog_open = (dq.dir == DIR_IN) && (req.conf == CONF_NONE);
          end
          if (req.op == OP_MREAD_FIRST || req.conf == CONF_11) n.mp_row = req.row;
        end
      end
      S_CMD1, S_CMD2: begin
        if (tick && !r.ph) begin
          // address phase may leave ale high; a command needs it low
          n.pins.ale = 1'b0;
          n.pins.cle = 1'b1;
          n.pins.dout = (r.state == S_CMD1) ? r.d.cmd1 : r.d.cmd2;
          n.pins.oe = 1'b1;
          n.pins.we_n = 1'b0;
          n.ph = 1'b1;
        end else if (tick) begin
          n.pins.we_n = 1'b1;
          n.ph = 1'b0;
          n.state = after(r.d, (r.state == S_CMD1) ? 3'd0 : 3'd3);
        end
      end
      S_ADDR: begin
        if (tick && !r.ph) begin
          n.pins.cle = 1'b0;
          n.pins.ale = 1'b1;
          n.pins.dout = addr_byte(r.rq, r.ab);
          n.pins.oe = 1'b1;
          n.pins.we_n = 1'b0;
          n.ph = 1'b1;
        end else if (tick) begin
          n.pins.we_n = 1'b1;
          n.ph = 1'b0;
          n.ab = 3'(r.ab + 1'b1);
          if (r.ab == r.d.a_last) n.state = after(r.d, 3'd1);
        end
      end
      S_DATA: begin
        if (r.d.dir == DIR_IN) begin
          // data input stalls while the fifo is empty
          if (tick && !r.ph && fifo_valid) begin
            n.pins.cle = 1'b0;
            n.pins.ale = 1'b0;
            n.pins.dout = fifo_data;
            n.pins.oe = 1'b1;
            n.pins.we_n = 1'b0;
            n.ph = 1'b1;
          end else if (tick && r.ph) begin
            n.pins.we_n = 1'b1;
            n.ph = 1'b0;
            n.cnt = `LEN_W'(r.cnt - 1'b1);
            if (r.cnt == `LEN_W'(1)) n.state = after(r.d, 3'd2);
          end
        end else begin
          // one byte per read strobe, port released
          if (tick && !r.ph) begin
            n.pins.cle = 1'b0;
            n.pins.ale = 1'b0;
            n.pins.oe = 1'b0;
            n.pins.re_n = 1'b0;
            n.ph = 1'b1;
          end else if (tick) begin
            n.pins.re_n = 1'b1;
            n.ph = 1'b0;
            n.rd_data = r.din_s2;
            n.rd_valid = 1'b1;
            if (r.rq.op inside {OP_STATUS, OP_STATUS_MULTI}) begin
              n.status = r.din_s2;
              n.fail = r.din_s2[`ST_FAIL_BIT];
            end
            n.cnt = `LEN_W'(r.cnt - 1'b1);
            if (r.cnt == `LEN_W'(1)) n.state = after(r.d, 3'd4);
          end
        end
      end
      S_WAITB: begin
        n.pins.oe = 1'b0;
        n.pins.cle = 1'b0;
        if (tick) begin
          n.wbc = 3'(r.wbc + 1'b1);
          if (r.wbc == `WB_TICKS) begin
            n.wbc = '0;
            n.state = S_BUSY;
          end
        end
      end
      S_BUSY: begin
        if (r.busy_s2) n.state = after(r.d, 3'd5);
      end
      default: n.state = S_IDLE;
    endcase
    if (r.state != S_IDLE && n.state == S_IDLE) begin
      n.done = 1'b1;
      n.pins.oe = 1'b0;
      n.pins.cle = 1'b0;
      n.pins.ale = 1'b0;
      if (r.rq.op == OP_MREAD_SECOND) n.mp_open = 1'b0;
    end
    n.pins.ce_n = (n.state == S_IDLE);
    // write protect lifted on request or multi read
    n.pins.wp_n = write_allow || n.mp_open || (n.state != S_IDLE && n.rq.op == OP_MREAD_SECOND);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
      r.pins.ce_n <= 1'b1;
      r.pins.we_n <= 1'b1;
      r.pins.re_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign op_done = r.done;
  assign op_refused = r.err;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
  assign status_byte = r.status;
  assign status_fail = r.fail;
  assign cmd_latch_en = r.pins.cle;
  assign addr_latch_en = r.pins.ale;
  assign chip_select_n = r.pins.ce_n;
  assign wr_strobe_n = r.pins.we_n;
  assign rd_strobe_n = r.pins.re_n;
  assign wr_protect_n = r.pins.wp_n;
  assign port_out = r.pins.dout;
  assign port_oe = r.pins.oe;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_we_low;
    !wr_strobe_n [*4];
  endsequence
  sequence s_we_rise;
    ##1 wr_strobe_n;
  endsequence

  property p_latch_excl;
    !(cmd_latch_en && addr_latch_en);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("cle and ale both high");

  property p_we_pulse;
    $fell(wr_strobe_n) |-> !chip_select_n && rd_strobe_n ##0 s_we_low ##0 s_we_rise;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe pulse malformed");

  property p_read_release;
    !rd_strobe_n |-> !port_oe && wr_strobe_n;
  endproperty
  a_read_release: assert property (p_read_release) else $error("port driven during read");

  property p_wp_data;
    (!wr_strobe_n && !cmd_latch_en && !addr_latch_en) |-> wr_protect_n;
  endproperty
  a_wp_data: assert property (p_wp_data) else $error("data input under protect");

  property p_busy_quiet;
    (r.state == S_BUSY) |-> wr_strobe_n && rd_strobe_n && !chip_select_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("strobe moved while busy");

  property p_busy_accept;
    (req_valid && req_ready && !r.busy_s2 && !(req.op inside {OP_STATUS, OP_STATUS_MULTI,
      OP_RESET})) |=> op_refused && r.state == S_IDLE;
  endproperty
  a_busy_accept: assert property (p_busy_accept) else $error("command taken while busy");

  property p_confirm_wait;
    (r.state == S_CMD2 && r.ph && tick && r.d.wait_rdy) |=> r.state == S_WAITB ##1
      (r.state == S_WAITB) [*2];
  endproperty
  a_confirm_wait: assert property (p_confirm_wait) else $error("no wait after confirm");

  property p_pair;
    (req_valid && req_ready && req.op == OP_MREAD_SECOND && !pair_ok(r.mp_row, req.row))
      |=> op_refused ##1 r.state == S_IDLE;
  endproperty
  a_pair: assert property (p_pair) else $error("bad district pair taken");

  property p_mread_wp;
    (r.state != S_IDLE && r.rq.op == OP_MREAD_SECOND) |-> wr_protect_n;
  endproperty
  a_mread_wp: assert property (p_mread_wp) else $error("protect low in multi read");

endmodule // nand_host_ctrl

`default_nettype wire

// ==== rtl/nand_host_cfg.svh ====
// constants for the flash host controller: command codes, address layout, timing
// assumes a 20 MHz controller clock and an 8-bit flash port
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

// command codes
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_COLR1 8'h05
`define CMD_COLR2 8'he0
`define CMD_CACHE_NEXT 8'h31
`define CMD_CACHE_LAST 8'h3f
`define CMD_PROG1 8'h80
`define CMD_PROG_2ND 8'h81
`define CMD_PROG_COL 8'h85
`define CMD_CONF_PROG 8'h10
`define CMD_CONF_CACHE 8'h15
`define CMD_CONF_MULTI 8'h11
`define CMD_COPY_RD2 8'h3a
`define CMD_COPY_PROG 8'h8c
`define CMD_MULTI_RD1 8'h60
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hd0
`define CMD_ID 8'h90
`define CMD_STATUS 8'h70
`define CMD_STATUS_MULTI 8'h71
`define CMD_RESET 8'hff
`define ID_ADDR_BYTE 8'h00

// address layout
`define COL_W 13
`define ROW_W 18
`define PAGE_W 6
`define LEN_W 13
`define DIST_BIT 6
`define HALF_BIT 17
`define ST_FAIL_BIT 0
`define AB_COL0 3'd0
`define AB_COL1 3'd1
`define AB_ROW0 3'd2
`define AB_ROW2 3'd4
`define AB_ID 3'd5

// timing: one strobe phase, and the wait before busy is trusted
`define CLK_PERIOD_NS 50
`define PHASE_NS 200
`define PHASE_CYC ((`PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_TICKS 3'd2
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8

`endif

// ==== rtl/nand_host_pkg.sv ====
// types of the flash host controller: requests, descriptors, pin bundle, state
// assumes nand_host_cfg.svh on the include path
`include "nand_host_cfg.svh"

package nand_host_pkg;

  typedef enum logic [4:0] {
    OP_READ, OP_READ_COL, OP_CACHE_NEXT, OP_CACHE_LAST, OP_MREAD_FIRST,
    OP_MREAD_SECOND, OP_PROG, OP_PROG_SECOND, OP_PROG_COL, OP_COPY_READ,
    OP_COPY_PROG, OP_ERASE, OP_ID, OP_STATUS, OP_STATUS_MULTI, OP_RESET, OP_DATA_OUT
  } op_t;

  typedef enum logic [1:0] {CONF_NONE, CONF_10, CONF_15, CONF_11} conf_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} dir_t;
  typedef enum logic [2:0] {S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WAITB, S_BUSY} state_t;

  typedef struct packed {
    op_t op;
    conf_t conf;
    logic [`COL_W-1:0] col;
    logic [`ROW_W-1:0] row;
    logic [`LEN_W-1:0] len;
  } req_t;

  typedef struct packed {
    logic has_cmd1;
    logic [7:0] cmd1;
    logic has_addr;
    logic [2:0] a_first;
    logic [2:0] a_last;
    dir_t dir;
    logic has_cmd2;
    logic [7:0] cmd2;
    logic wait_rdy;
  } desc_t;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] dout;
    logic oe;
  } pins_t;

  typedef struct packed {
    state_t state;
    logic ph;
    desc_t d;
    req_t rq;
    logic [`LEN_W-1:0] cnt;
    logic [2:0] ab;
    logic [2:0] wbc;
    logic busy_s1;
    logic busy_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic rd_ctx;
    logic cache_act;
    logic mp_open;
    logic mp_prog;
    logic prog_open;
    logic [`ROW_W-1:0] mp_row;
    logic [7:0] status;
    logic fail;
    logic err;
    logic done;
    logic [7:0] rd_data;
    logic rd_valid;
    pins_t pins;
  } ctl_t;

endpackage

// ==== rtl/phase_tick.sv ====
// strobe phase enable: one-cycle pulse every DIV clocks
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none

module phase_tick
  import nand_host_pkg::*;
#(
  parameter int DIV = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  output logic tick
);

  localparam int W = $clog2(DIV + 1);
  typedef struct packed {logic [W-1:0] cnt;} tick_st_t;
  tick_st_t r, n;

  // wrap counter
  always_comb begin
    n = r;
    n.cnt = tick ? '0 : W'(r.cnt + 1'b1);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = (r.cnt == W'(DIV - 1));

endmodule // phase_tick

`default_nettype wire

// ==== rtl/byte_fifo.sv ====
// small fifo for program data, valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none

module byte_fifo
  import nand_host_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t r, n;
  logic push, pop;

  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = AW'(r.wp + 1'b1);
    end
    if (pop) begin
      n.rp = AW'(r.rp + 1'b1);
    end
    if (push && !pop) begin
      n.cnt = (AW+1)'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      n.cnt = (AW+1)'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule // byte_fifo

`default_nettype wire

// ==== dv/nand_dev_model.sv ====
// flash device model: command latch, busy timer, column read-out
// assumes one controller on the port; busy level stands for the pulled-up pin
`timescale 1ns/1ps
`default_nettype none

module nand_dev_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic clock,
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic fail_in,
  input wire logic [7:0] port_out,
  input wire logic port_oe,
  output logic [7:0] port_lvl,
  output logic busy_n
);
  logic [7:0] cmd = 8'h00;
  logic [12:0] col = 13'h0000;
  logic [2:0] ac = 3'h0;
  logic [7:0] dout = 8'h00;
  logic [7:0] last = 8'h00;
  logic hit;
  time bend = 0;
  ////////////////////////////////////////////////////////////////
  // latch on write rise, output on read fall
  always @(posedge we_n or negedge re_n) begin
    hit = port_out inside {8'h10, 8'h15, 8'h11, 8'hd0};
    if (!re_n) begin
      dout = (cmd inside {8'h70, 8'h71}) ? {wp_n, busy_n, busy_n, 4'h0, fail_in} :
        col[7:0] ^ 8'h5a;
      col = col + 13'h0001;
    end else if (!ce_n && cle && !ale && (busy_n || port_out inside {8'h70, 8'h71, 8'hff})) begin
      cmd = port_out;
      ac = 3'h0;
      if (port_out inside {8'h30, 8'h31, 8'h3a, 8'h3f, 8'hff} || (wp_n && hit))
        bend = $time + BUSY_CYC * 50;
    end else if (!ce_n && ale && !cle) begin
      // column bytes first, also after 85h
      if (ac == 3'h0) col[7:0] = port_out;
      if (ac == 3'h1) col[12:8] = port_out[4:0];
      ac = ac + 3'h1;
    end
  end
  // busy level and port history
  always @(posedge clock) begin
    busy_n <= ($time >= bend);
    last <= port_lvl;
  end
  // released port shows the inverse of its last level
  assign port_lvl = port_oe ? port_out : ((!re_n && !ce_n) ? dout : ~last);
endmodule // nand_dev_model
`default_nettype wire

// ==== dv/nand_host_ctrl_test.sv ====
// testbench of the flash host controller with a device model
// assumes the design package compiled first
`timescale 1ns/1ps
`default_nettype none

module nand_host_ctrl_test;
  import nand_host_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  req_t req = '0;
  logic req_valid = 1'b0;
  logic write_allow = 1'b1;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic fail_in = 1'b1;
  logic req_ready, op_done, op_refused, wr_ready, rd_valid, status_fail, cle, ale, ce_n;
  logic we_n, re_n, wp_n, port_oe, busy_n;
  logic [7:0] rd_data, status_byte, port_out, port_lvl;
  logic [7:0] rq[$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  nand_host_ctrl uut (.clock(clock), .reset_n(reset_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .op_done(op_done), .op_refused(op_refused),
    .write_allow(write_allow), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .status_byte(status_byte),
    .status_fail(status_fail), .cmd_latch_en(cle), .addr_latch_en(ale),
    .chip_select_n(ce_n), .wr_strobe_n(we_n), .rd_strobe_n(re_n), .wr_protect_n(wp_n),
    .port_out(port_out), .port_oe(port_oe), .port_in(port_lvl), .busy_flag_n(busy_n));
  nand_dev_model dev (.clock(clock), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .fail_in(fail_in), .port_out(port_out), .port_oe(port_oe),
    .port_lvl(port_lvl), .busy_n(busy_n));

  ////////////////////////////////////////////////////////////////
  // clock, read capture, hang limit
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request, then wait for its end and judge refusal
  task automatic run(op_t op, conf_t cf, logic [12:0] c, logic [17:0] r, logic [12:0] n,
      logic refuse);
    int k;
    @(negedge clock);
    req = '{op: op, conf: cf, col: c, row: r, len: n};
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 500) begin @(negedge clock); k++; end
    @(negedge clock);
    req_valid = 1'b0;
    k = 0;
    while (op_done !== 1'b1 && op_refused !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    chk("done", op_done, !refuse);
    chk("refused", op_refused, refuse);
    // one more edge so the last read byte is queued
    @(negedge clock);
  endtask

  task automatic chk_rd(logic [7:0] c0, int n);
    chk("count", 8'(rq.size()), 8'(n));
    for (int i = 0; i < n && i < rq.size(); i++) begin
      chk("byte", rq[i], (c0 + 8'(i)) ^ 8'h5a);
    end
    rq.delete();
  endtask

  task automatic t_status();
    run(OP_STATUS, CONF_NONE, 0, 0, 1, 0);
    chk("status", status_byte, 8'he1);
    chk("fail", status_fail, 1'b1);
    run(OP_RESET, CONF_NONE, 0, 0, 0, 0);
    fail_in = 1'b0;
    run(OP_STATUS_MULTI, CONF_NONE, 0, 0, 1, 0);
    chk("status", status_byte, 8'he0);
    chk("fail", status_fail, 1'b0);
    rq.delete();
  endtask

  task automatic t_read();
    run(OP_READ, CONF_NONE, 13'h0005, 18'h00041, 0, 0);
    run(OP_DATA_OUT, CONF_NONE, 0, 0, 3, 0);
    chk_rd(8'h05, 3);
    run(OP_READ_COL, CONF_NONE, 13'h0100, 0, 2, 0);
    chk_rd(8'h00, 2);
    run(OP_ID, CONF_NONE, 0, 0, 2, 0);
    chk_rd(8'h00, 2);
  endtask

  task automatic t_cache();
    run(OP_READ, CONF_NONE, 0, 18'h00080, 0, 0);
    run(OP_CACHE_NEXT, CONF_NONE, 0, 0, 0, 0);
    run(OP_PROG, CONF_10, 0, 0, 1, 1);
    run(OP_CACHE_LAST, CONF_NONE, 0, 0, 0, 0);
  endtask

  task automatic t_refuse();
    write_allow = 1'b0;
    run(OP_ERASE, CONF_NONE, 0, 18'h00040, 0, 1);
    write_allow = 1'b1;
    run(OP_PROG_COL, CONF_NONE, 13'h0010, 0, 1, 1);
    run(OP_MREAD_SECOND, CONF_NONE, 0, 18'h00001, 0, 1);
    run(OP_MREAD_FIRST, CONF_NONE, 0, 18'h00041, 0, 0);
    run(OP_MREAD_SECOND, CONF_NONE, 0, 18'h00001, 0, 0);
    run(OP_ERASE, CONF_NONE, 0, 18'h00040, 0, 0);
  endtask

  task automatic t_prog();
    for (int i = 0; i < 8; i++) begin
      @(negedge clock);
      wr_data = 8'(i);
      wr_valid = 1'b1;
    end
    @(negedge clock);
    wr_valid = 1'b0;
    chk("full", wr_ready, 1'b0);
    run(OP_PROG, CONF_11, 0, 18'h00042, 2, 0);
    run(OP_PROG_SECOND, CONF_10, 0, 18'h00002, 2, 0);
    run(OP_PROG, CONF_NONE, 0, 18'h00042, 1, 0);
    run(OP_PROG_COL, CONF_10, 13'h0020, 0, 1, 0);
    run(OP_COPY_READ, CONF_NONE, 0, 18'h00080, 0, 0);
    run(OP_COPY_PROG, CONF_15, 0, 18'h000c0, 2, 0);
    chk("drained", wr_ready, 1'b1);
  endtask

  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_status();
    t_read();
    t_cache();
    t_refuse();
    t_prog();
    finish_test();
  end
endmodule // nand_host_ctrl_test
`default_nettype wire
